/* bic_top.sv */
`timescale 1ns/1ns
// Functional notes
// [RULE1] Greater-than mode: result high above threshold, low below it.
// [RULE2] Less-than mode: result high at or below threshold, low above it.
// [RULE3] Each datapath debounces its comparator, stepping every 20 us tick.
// [RULE4] Debounce length field holds up to 8191 ticks, 163.82 ms.
// [RULE5] Zero length bypasses the debounce, passing the comparator straight through.
// [RULE6] Filter register bit 14 picks up/clear (0, reset) or up/down (1).
// [RULE7] Up/clear, output low: count up while high, clear when low early.
// [RULE8] Up/clear, output high: hold, count down when low, reload when high again.
// [RULE9] Up/down: count up saturating at length, down when low; output follows ends.
// [RULE10] All filter outputs, both channels, appear as status bits; the output-path bits show the final result after invalid mode.
// [RULE11] Output-path results drive first pin and second pin, chosen by control bit 2.
// [RULE12] Protection disabled means invalid mode until protection returns.
// [RULE13] Invalid mode field: force value, pass, toggle entry value, hold.
// [RULE14] Load is off when both load enable bits are zero.
// [RULE15] On input high, pulse current for the set time, then constant current.
// [RULE16] Pulse current is an 8-bit code, 0.2 mA a step.
// [RULE17] Pulse time is a 12-bit code in 10 us steps.
// [RULE18] Constant current is a 6-bit code, 0.1 mA a step.
// [RULE19] Low idle mode starts the pulse once the sample reaches the rise threshold.
// [RULE20] High idle mode starts the pulse as soon as input voltage appears.
// [RULE21] Pulse current only while the channel output is low.
// [RULE22] Host sets output length at least 3 and rise threshold below high threshold.
// [RULE23] Filter register bit 15 enables that datapath's comparator and debounce. Here it gates the debounce only; the comparator runs regardless.
// [RULE24] Both channels share one set of datapath settings.
// [RULE25] Greater-than mode leaves the result unchanged on an equal sample.
// [RULE26] Each channel has its own comparator, counter and output state.
module bic_top
  import bic_pkg::*;
(
  input wire logic CORE_CLK, // Core clock, 20 MHz.
  input wire logic SRST, // Synchronous reset, active high.
  input wire logic CE, // Clock enable, freezes all state when low.
  input wire logic SAMPLE_VALID, // One-cycle strobe, a new sample is present.
  input wire logic SAMPLE_CHANNEL, // Channel of the sample, 0 first input, 1 second.
  input wire logic [SAMPLE_W-1:0] SAMPLE_DATA, // Sample code.
  input wire logic PROTECT_EN, // Register protection on; low means invalid mode.
  input wire logic IRQ_LEVEL_N, // Interrupt level shown on the shared pin.
  input wire logic [REG_W-1:0] REG_CONTROL, // Control register.
  input wire logic [REG_W-1:0] REG_DATAPATH_CONTROL, // Modes, invalid-mode field.
  input wire logic [4*SAMPLE_W-1:0] REG_HIGH_THRESHOLDS, // Byte per datapath.
  input wire logic [REG_W-1:0] REG_OUTPUT_PATH_DEBOUNCE, // Output path filter.
  input wire logic [REG_W-1:0] REG_WARNING_A_DEBOUNCE, // Warning A filter.
  input wire logic [REG_W-1:0] REG_WARNING_B_DEBOUNCE, // Warning B filter.
  input wire logic [REG_W-1:0] REG_WARNING_C_DEBOUNCE, // Warning C filter.
  input wire logic [REG_W-1:0] REG_PULSE_CURRENT_LEVEL, // Pulse current code.
  input wire logic [REG_W-1:0] REG_PULSE_DURATION, // Pulse time in 10 us.
  input wire logic [REG_W-1:0] REG_HOLD_CURRENT_LEVEL, // Constant current code.
  input wire logic [REG_W-1:0] REG_LOAD_RISE_THRESHOLD, // Rise threshold.
  input wire logic [REG_W-1:0] REG_LOAD_ENABLE, // Load enable bits.
  input wire logic [REG_W-1:0] REG_LOAD_CONTROL, // Idle mode select.
  output logic FIRST_OUTPUT, // First output pin.
  output logic SECOND_OUTPUT, // Second output or interrupt pin level.
  output logic SECOND_OE, // Drive enable of the shared pin.
  output logic [2*NUM_DP-1:0] FILTER_STATUS, // Filter results, two bits a datapath.
  output logic INVALID_ACTIVE, // Invalid mode in force.
  output logic [NUM_CH-1:0] LOAD_PULSE_ON, // Pulsed current on, per channel.
  output logic [NUM_CH-1:0] LOAD_HOLD_ON, // Constant current on, per channel.
  output logic [PULSE_CODE_W-1:0] LOAD_PULSE_CODE, // Pulse current code.
  output logic [HOLD_CODE_W-1:0] LOAD_HOLD_CODE // Constant current code.
);
  function automatic logic [1:0] dp_mode(input logic [REG_W-1:0] ctrl, input int d);
    return ctrl[CMP_MODE_LSB + CMP_MODE_W * d +: CMP_MODE_W];
  endfunction

  function automatic logic cmp_next(input logic [1:0] mode, input logic [SAMPLE_W-1:0] s,
                                    input logic [SAMPLE_W-1:0] thr, input logic prev);
    logic r;
    r = prev;
    case (mode)
      CMP_GT: begin
        if (s > thr) begin
          r = 1'b1;
        end else if (s < thr) begin
          r = 1'b0;
        end
      end
      CMP_LT: r = (s <= thr);
      // Hysteretic and midrange modes are not built here; the result holds.
      default: r = prev;
    endcase
    return r;
  endfunction

  logic [REG_W-1:0] dp_cfg [NUM_DP];
  logic [NUM_DP-1:0] cmp_q [NUM_CH];
  logic [NUM_DP-1:0] dbn_out [NUM_CH];
  logic [SAMPLE_W-1:0] sample_q [NUM_CH];
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick20;
  logic tick10;
  logic invalid;
  logic inval_q;
  logic [NUM_CH-1:0] entry_q;
  logic [NUM_CH-1:0] final_q;
  logic [NUM_CH-1:0] final_d;
  logic sec_out_q;
  logic sec_oe_q;
  logic [2*NUM_DP-1:0] status_q;
  logic [1:0] inv_mode;

  assign dp_cfg[0] = REG_OUTPUT_PATH_DEBOUNCE;
  assign dp_cfg[1] = REG_WARNING_A_DEBOUNCE;
  assign dp_cfg[2] = REG_WARNING_B_DEBOUNCE;
  assign dp_cfg[3] = REG_WARNING_C_DEBOUNCE;

  ////////////////////////////////////////////////////////////////////////////
  // Channel tick: 20 us for the filters, every 10 us for the pulse timer.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      tick_cnt_q <= '0;
    end else if (CE) begin
      tick_cnt_q <= tick20 ? '0 : tick_cnt_q + TICK_W'(1);
    end
  end

  assign tick20 = (tick_cnt_q == TICK20_LAST); // RULE3
  assign tick10 = tick20 || (tick_cnt_q == TICK10_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Comparators. Only the sampled channel updates, so channels stay apart.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cmp_q[c] <= '0;
        sample_q[c] <= '0;
      end
    end else if (CE && SAMPLE_VALID) begin
      sample_q[SAMPLE_CHANNEL] <= SAMPLE_DATA;
      for (int d = 0; d < NUM_DP; d++) begin
        // One shared setting set serves both channels.
        cmp_q[SAMPLE_CHANNEL][d] <= cmp_next(dp_mode(REG_DATAPATH_CONTROL, d), SAMPLE_DATA, // RULE24 RULE26
          REG_HIGH_THRESHOLDS[SAMPLE_W * d +: SAMPLE_W], cmp_q[SAMPLE_CHANNEL][d]); // RULE1 RULE2 RULE25
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debounce filters, one for each datapath of each channel.
  for (genvar gc = 0; gc < NUM_CH; gc++) begin : g_ch
    for (genvar gd = 0; gd < NUM_DP; gd++) begin : g_dp
      bic_filt_if fif ();
      assign fif.tick = tick20;
      assign fif.cmp = cmp_q[gc][gd];
      assign fif.en = dp_cfg[gd][DBN_EN_BIT]; // RULE23
      assign fif.updown = dp_cfg[gd][DBN_MODE_BIT]; // RULE6
      assign fif.len = dp_cfg[gd][DBN_LEN_W-1:0]; // RULE4
      assign dbn_out[gc][gd] = fif.out;
      bic_debounce u_dbn (
        .clk(CORE_CLK),
        .srst(SRST),
        .ce(CE),
        .port(fif)
      );
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Invalid mode override of the two output-path results.
  assign invalid = !PROTECT_EN; // RULE12
  assign inv_mode = REG_DATAPATH_CONTROL[INVALID_LSB +: 2];

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      final_d[c] = dbn_out[c][DP_OUT];
      if (invalid) begin
        case (inv_mode) // RULE13
          INV_FORCE: final_d[c] = REG_DATAPATH_CONTROL[FORCE_BIT];
          INV_PASS: final_d[c] = dbn_out[c][DP_OUT];
          // On the entry cycle the entry value is still the current one.
          INV_TOGGLE: final_d[c] = inval_q ? !entry_q[c] : !final_q[c];
          INV_HOLD: final_d[c] = final_q[c];
          default: final_d[c] = final_q[c];
        endcase
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      inval_q <= 1'b0;
      entry_q <= '0;
      final_q <= '0;
    end else if (CE) begin
      inval_q <= invalid;
      if (invalid && !inval_q) begin
        entry_q <= final_q;
      end
      final_q <= final_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and status.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sec_out_q <= 1'b0;
      sec_oe_q <= 1'b1;
      status_q <= '0;
    end else if (CE) begin
      if (REG_CONTROL[PIN_SEL_BIT]) begin // RULE11
        // Interrupt use makes the pin open drain: it only ever pulls low.
        sec_out_q <= 1'b0;
        sec_oe_q <= !IRQ_LEVEL_N;
      end else begin
        sec_out_q <= final_d[1];
        sec_oe_q <= 1'b1;
      end
      for (int d = 0; d < NUM_DP; d++) begin
        for (int c = 0; c < NUM_CH; c++) begin
          status_q[NUM_CH * d + c] <= (d == DP_OUT) ? final_d[c] : dbn_out[c][d]; // RULE10
        end
      end
    end
  end

  assign FIRST_OUTPUT = final_q[0]; // RULE11
  assign SECOND_OUTPUT = sec_out_q;
  assign SECOND_OE = sec_oe_q;
  assign FILTER_STATUS = status_q;
  assign INVALID_ACTIVE = inval_q;

  ////////////////////////////////////////////////////////////////////////////
  // Programmable load, one sequencer per channel.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      LOAD_PULSE_CODE <= '0;
      LOAD_HOLD_CODE <= '0;
    end else if (CE) begin
      LOAD_PULSE_CODE <= REG_PULSE_CURRENT_LEVEL[PULSE_CODE_W-1:0]; // RULE16
      LOAD_HOLD_CODE <= REG_HOLD_CURRENT_LEVEL[HOLD_CODE_W-1:0]; // RULE18
    end
  end

  for (genvar gc = 0; gc < NUM_CH; gc++) begin : g_load
    bic_load_state_t st_q;
    bic_load_state_t st_d;
    logic [PULSE_DUR_W-1:0] dur_q;
    logic pulse_q;
    logic hold_q;
    logic load_en;
    logic high_idle;
    logic present;
    logic [PULSE_DUR_W-1:0] dur_cfg;

    assign load_en = REG_LOAD_ENABLE[LOAD_EN_LSB + gc]; // RULE14
    assign high_idle = REG_LOAD_CONTROL[IDLE_MODE_BIT];
    assign dur_cfg = REG_PULSE_DURATION[PULSE_DUR_W-1:0]; // RULE17
    // Input counts as present at the rise threshold, or at any voltage in high idle.
    assign present = high_idle ? (sample_q[gc] != '0) : // RULE20
      (sample_q[gc] >= REG_LOAD_RISE_THRESHOLD[RISE_W-1:0]); // RULE19

    always_comb begin
      st_d = st_q;
      case (st_q)
        LOAD_IDLE: begin
          if (load_en && present && !final_q[gc]) begin // RULE21
            st_d = (dur_cfg == '0) ? LOAD_HOLD : LOAD_PULSE;
          end
        end
        LOAD_PULSE: begin
          if (!load_en) begin
            st_d = LOAD_IDLE;
          end else if (final_q[gc]) begin // RULE21
            st_d = LOAD_HOLD;
          end else if (tick10 && dur_q >= dur_cfg - PULSE_DUR_W'(1)) begin // RULE15
            st_d = LOAD_HOLD;
          end
        end
        LOAD_HOLD: begin
          // Stays on until the load is disabled or the input falls away while the output is low, so it cannot re-trigger.
          if (!load_en || (!present && !final_q[gc])) begin
            st_d = LOAD_IDLE;
          end
        end
        default: st_d = LOAD_IDLE;
      endcase
    end

    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        st_q <= LOAD_IDLE;
        dur_q <= '0;
        pulse_q <= 1'b0;
        hold_q <= 1'b0;
      end else if (CE) begin
        st_q <= st_d;
        pulse_q <= (st_d == LOAD_PULSE);
        hold_q <= (st_d == LOAD_HOLD); // RULE15
        if (st_q != LOAD_PULSE) begin
          dur_q <= '0;
        end else if (tick10) begin
          dur_q <= dur_q + PULSE_DUR_W'(1);
        end
      end
    end

    assign LOAD_PULSE_ON[gc] = pulse_q;
    assign LOAD_HOLD_ON[gc] = hold_q;

    AST_PULSE_LOW: // RULE21
    assert property (@(posedge CORE_CLK) disable iff (SRST) $rose(pulse_q) |-> !$past(final_q[gc]))
      else $error("Pulse started while output high.");
    COV_PULSE_DONE: cover property (@(posedge CORE_CLK) disable iff (SRST) pulse_q ##1 hold_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  AST_GT_HIGH: // RULE1
  assert property (CE && SAMPLE_VALID && !SAMPLE_CHANNEL && dp_mode(REG_DATAPATH_CONTROL, 2) == CMP_GT
    && SAMPLE_DATA > REG_HIGH_THRESHOLDS[2*SAMPLE_W +: SAMPLE_W] |=> cmp_q[0][2])
    else $error("Greater-than result not high.");
  AST_GT_LOW: // RULE1
  assert property (CE && SAMPLE_VALID && SAMPLE_CHANNEL && dp_mode(REG_DATAPATH_CONTROL, 0) == CMP_GT
    && SAMPLE_DATA < REG_HIGH_THRESHOLDS[SAMPLE_W-1:0] |=> !cmp_q[1][0])
    else $error("Greater-than result not low.");
  AST_GT_EQUAL: // RULE25
  assert property (SAMPLE_VALID && !SAMPLE_CHANNEL && dp_mode(REG_DATAPATH_CONTROL, 0) == CMP_GT
    && SAMPLE_DATA == REG_HIGH_THRESHOLDS[SAMPLE_W-1:0] |=> $stable(cmp_q[0][0]))
    else $error("Equal sample changed greater-than result.");
  AST_LT: // RULE2
  assert property (CE && SAMPLE_VALID && !SAMPLE_CHANNEL && dp_mode(REG_DATAPATH_CONTROL, 1) == CMP_LT
    |=> cmp_q[0][1] == ($past(SAMPLE_DATA) <= $past(REG_HIGH_THRESHOLDS[SAMPLE_W +: SAMPLE_W])))
    else $error("Less-than result wrong.");
  AST_TICK: // RULE3
  assert property (CE && tick20 |=> (CE [*8] |=> tick_cnt_q == TICK_W'(8)))
    else $error("Channel tick counter did not restart.");
  AST_FORCE: // RULE13
  assert property (CE && invalid && inv_mode == INV_FORCE |=> final_q == {NUM_CH{$past(REG_DATAPATH_CONTROL[FORCE_BIT])}})
    else $error("Forced value not driven.");
  AST_TRACK: // RULE12
  assert property (CE && !invalid |=> final_q[0] == $past(dbn_out[0][DP_OUT]) && !INVALID_ACTIVE)
    else $error("Output not tracking datapath outside invalid mode.");
  AST_TOGGLE: // RULE13
  assert property (CE && !invalid ##1 CE && invalid && inv_mode == INV_TOGGLE |=> final_q == ~$past(final_q))
    else $error("Toggle of entry value wrong.");
  AST_LOAD_OFF: // RULE14
  assert property (CE && REG_LOAD_ENABLE[LOAD_EN_LSB +: NUM_CH] == '0 |=> LOAD_PULSE_ON == '0 && LOAD_HOLD_ON == '0)
    else $error("Load active while disabled.");
  AST_PIN_SEL: // RULE11
  assert property (CE && !REG_CONTROL[PIN_SEL_BIT] |=> SECOND_OUTPUT == final_q[1] && SECOND_OE)
    else $error("Second pin not showing output path.");
  COV_INVALID_TOGGLE: cover property (CE && invalid && inv_mode == INV_TOGGLE && !inval_q);
  COV_IRQ_PIN: cover property (REG_CONTROL[PIN_SEL_BIT] && !IRQ_LEVEL_N ##1 SECOND_OE);
endmodule

/* bic_pkg.sv */
package bic_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CHANNEL_UPDATE_NS = 20000;
  localparam int PULSE_STEP_NS = 10000;
  localparam int TICK20_CYC = CHANNEL_UPDATE_NS / CLK_PERIOD_NS;
  localparam int TICK10_CYC = PULSE_STEP_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 9;
  localparam logic [TICK_W-1:0] TICK20_LAST = TICK_W'(TICK20_CYC - 1);
  localparam logic [TICK_W-1:0] TICK10_LAST = TICK_W'(TICK10_CYC - 1);
  localparam int NUM_CH = 2;
  localparam int NUM_DP = 4;
  localparam int DP_OUT = 0;
  localparam int REG_W = 16;
  localparam int SAMPLE_W = 8;
  // 8191 ticks of 20 us give 163.82 ms.
  localparam int DBN_LEN_W = 13;
  localparam int DBN_EN_BIT = 15;
  localparam int DBN_MODE_BIT = 14;
  localparam int CMP_MODE_LSB = 6;
  localparam int CMP_MODE_W = 2;
  localparam logic [1:0] CMP_HYST = 2'h0;
  localparam logic [1:0] CMP_MID = 2'h1;
  localparam logic [1:0] CMP_GT = 2'h2;
  localparam logic [1:0] CMP_LT = 2'h3;
  localparam int FORCE_BIT = 3;
  localparam int INVALID_LSB = 4;
  localparam logic [1:0] INV_FORCE = 2'h0;
  localparam logic [1:0] INV_PASS = 2'h1;
  localparam logic [1:0] INV_TOGGLE = 2'h2;
  localparam logic [1:0] INV_HOLD = 2'h3;
  localparam int PIN_SEL_BIT = 2;
  localparam int LOAD_EN_LSB = 14;
  localparam int IDLE_MODE_BIT = 0;
  localparam int PULSE_CODE_W = 8;
  localparam int PULSE_DUR_W = 12;
  localparam int HOLD_CODE_W = 6;
  localparam int RISE_W = 8;
  typedef enum logic [1:0] {LOAD_IDLE, LOAD_PULSE, LOAD_HOLD} bic_load_state_t;
endpackage

/* bic_filt_if.sv */
`timescale 1ns/1ns
interface bic_filt_if;
  import bic_pkg::*;
  logic tick;
  logic cmp;
  logic en;
  logic updown;
  logic [DBN_LEN_W-1:0] len;
  logic out;
  modport filt (input tick, input cmp, input en, input updown, input len, output out);
  modport ctl (output tick, output cmp, output en, output updown, output len, input out);
endinterface

/* bic_debounce.sv */
`timescale 1ns/1ns
module bic_debounce
  import bic_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable.
  bic_filt_if.filt port // Comparator in, filter result out.
);
  logic [DBN_LEN_W-1:0] cnt_q;
  logic out_q;
  logic at_len;
  logic at_floor;

  // Lowering the length below the count must still saturate, hence the compare.
  assign at_len = cnt_q >= (port.len - DBN_LEN_W'(1));
  assign at_floor = cnt_q <= DBN_LEN_W'(1);
  assign port.out = out_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (ce) begin
      if (!port.en) begin // RULE23
        cnt_q <= '0;
        out_q <= 1'b0;
      end else if (port.len == '0) begin // RULE5
        cnt_q <= '0;
        out_q <= port.cmp;
      end else if (port.tick) begin // RULE3
        if (port.cmp) begin
          if (!port.updown && out_q) begin
            cnt_q <= port.len; // RULE8
          end else if (at_len) begin // RULE9
            cnt_q <= port.len;
            out_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + DBN_LEN_W'(1);
          end
        end else if (!port.updown && !out_q) begin
          cnt_q <= '0; // RULE7
        end else if (at_floor) begin
          cnt_q <= '0;
          out_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - DBN_LEN_W'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  AST_BYPASS: // RULE5
  assert property (ce && port.en && port.len == '0 |=> out_q == $past(port.cmp))
    else $error("Bypassed filter did not follow comparator.");
  AST_UC_CLEAR: // RULE7
  assert property (ce && port.en && port.len != '0 && port.tick && !port.updown && !out_q && !port.cmp
    |=> cnt_q == '0 && !out_q)
    else $error("Up/clear counter not cleared.");
  AST_DISABLED: // RULE23
  assert property (ce && !port.en |=> !out_q && cnt_q == '0)
    else $error("Disabled filter not quiet.");
  AST_UD_SAT: // RULE9
  assert property (port.en && port.len != '0 && port.updown |-> cnt_q <= port.len || $changed(port.len))
    else $error("Up/down counter passed the length.");
  COV_RISE: cover property (port.len != '0 && $rose(out_q));
endmodule

/* bic_field_model.sv */
`timescale 1ns/1ns
module bic_field_model
  import bic_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic rst, // Reset, restarts the sample phase.
  input wire logic [SAMPLE_W-1:0] level0, // First input level.
  input wire logic [SAMPLE_W-1:0] level1, // Second input level.
  output logic valid, // Sample strobe.
  output logic chan, // Sample channel.
  output logic [SAMPLE_W-1:0] data // Sample code.
);
  // Each input is sampled once per 400 clocks, locked to reset release so that a
  // sample never lands beside the 20 us tick and every tick sees one fresh sample.
  int ph;
  initial begin
    valid = 1'b0;
    chan = 1'b0;
    data = 8'h00;
  end
  // Between samples the data lines toggle each clock between the last code and its inverse, not a stale copy.
  always @(posedge clk) begin
    ph <= (rst || ph == 399) ? 0 : ph + 1;
    valid <= !rst && (ph == 99 || ph == 149);
    chan <= ph == 149;
    data <= ph == 149 ? level1 : ph == 99 ? level0 : ~data;
  end
endmodule

/* tb.sv */
`timescale 1ns/1ns
module tb;
  import bic_pkg::*;
  logic CORE_CLK, SRST, CE, SAMPLE_VALID, SAMPLE_CHANNEL, PROTECT_EN, IRQ_LEVEL_N;
  logic [SAMPLE_W-1:0] SAMPLE_DATA, lv0, lv1;
  logic [REG_W-1:0] REG_CONTROL, REG_DATAPATH_CONTROL, REG_OUTPUT_PATH_DEBOUNCE, REG_WARNING_A_DEBOUNCE;
  logic [REG_W-1:0] REG_WARNING_B_DEBOUNCE, REG_WARNING_C_DEBOUNCE, REG_PULSE_CURRENT_LEVEL, REG_PULSE_DURATION;
  logic [REG_W-1:0] REG_HOLD_CURRENT_LEVEL, REG_LOAD_RISE_THRESHOLD, REG_LOAD_ENABLE, REG_LOAD_CONTROL;
  logic [4*SAMPLE_W-1:0] REG_HIGH_THRESHOLDS;
  logic FIRST_OUTPUT, SECOND_OUTPUT, SECOND_OE, INVALID_ACTIVE;
  logic [2*NUM_DP-1:0] FILTER_STATUS;
  logic [NUM_CH-1:0] LOAD_PULSE_ON, LOAD_HOLD_ON, snap;
  logic [PULSE_CODE_W-1:0] LOAD_PULSE_CODE;
  logic [HOLD_CODE_W-1:0] LOAD_HOLD_CODE;
  logic [REG_W-1:0] flt [4];
  int fails, tests_run, cnt [4][2];
  bit fo [4][2], cm [4][2], ent [2];
  int seq [14] = '{8'h90, 8'h90, 8'h70, 8'h90, 8'h90, 8'h90, 8'h80, 8'h70, 8'h90, 8'h70, 8'h70, 8'h70, 8'h70, 8'h80};
  assign REG_OUTPUT_PATH_DEBOUNCE = flt[0];
  assign REG_WARNING_A_DEBOUNCE = flt[1];
  assign REG_WARNING_B_DEBOUNCE = flt[2];
  assign REG_WARNING_C_DEBOUNCE = flt[3];
  bic_top uut (.*);
  bic_field_model fld (.clk(CORE_CLK), .rst(SRST), .level0(lv0), .level1(lv1), .valid(SAMPLE_VALID),
    .chan(SAMPLE_CHANNEL), .data(SAMPLE_DATA));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (e !== g) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic rst;
    SRST = 1'b1;
    repeat (2) @(posedge CORE_CLK);
    #1 chk("reset status", 8'h00, FILTER_STATUS);
    chk("reset oe", 8'h01, SECOND_OE);
    SRST = 1'b0;
    foreach (cnt[d, c]) begin
      cnt[d][c] = 0;
      fo[d][c] = 0;
      cm[d][c] = 0;
    end
  endtask
  // One model step stands for one 20 us tick, since every tick sees one sample per input.
  task automatic model(int a, int b);
    int s, l, t;
    foreach (cnt[d, c]) begin
      s = c ? b : a;
      t = REG_HIGH_THRESHOLDS[8*d +: 8];
      l = flt[d][12:0];
      if (REG_DATAPATH_CONTROL[6+2*d +: 2] == CMP_GT && s != t) cm[d][c] = s > t;
      if (REG_DATAPATH_CONTROL[6+2*d +: 2] == CMP_LT) cm[d][c] = s <= t;
      if (!flt[d][15]) begin
        cnt[d][c] = 0;
        fo[d][c] = 0;
      end else if (l == 0) begin
        fo[d][c] = cm[d][c];
      end else if (cm[d][c]) begin
        cnt[d][c] = (fo[d][c] && !flt[d][14]) ? l : (cnt[d][c] < l ? cnt[d][c] + 1 : l);
        if (cnt[d][c] == l) fo[d][c] = 1;
      end else begin
        cnt[d][c] = ((!fo[d][c] && !flt[d][14]) || cnt[d][c] == 0) ? 0 : cnt[d][c] - 1;
        if (cnt[d][c] == 0) fo[d][c] = 0;
      end
    end
  endtask
  function automatic bit fin(int c);
    logic [1:0] m;
    m = REG_DATAPATH_CONTROL[INVALID_LSB +: 2];
    if (PROTECT_EN) return fo[0][c];
    if (m == INV_FORCE) return REG_DATAPATH_CONTROL[FORCE_BIT];
    if (m == INV_PASS) return fo[0][c];
    return m == INV_TOGGLE ? !ent[c] : ent[c];
  endfunction
  task automatic step(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] st;
    lv0 = a;
    lv1 = b;
    IRQ_LEVEL_N = 1'($urandom_range(1));
    do @(posedge CORE_CLK); while (SAMPLE_VALID !== 1'b1 || SAMPLE_CHANNEL !== 1'b0);
    repeat (150) @(posedge CORE_CLK);
    #1 snap = LOAD_PULSE_ON;
    repeat (235) @(posedge CORE_CLK);
    #1 model(a, b);
    st = 0;
    foreach (fo[d, c]) st[2*d+c] = d ? fo[d][c] : fin(c);
    chk("status", st, FILTER_STATUS);
    chk("first", st[0], FIRST_OUTPUT);
    chk("second", st[1] & !REG_CONTROL[2], SECOND_OUTPUT);
    chk("oe", !REG_CONTROL[2] | !IRQ_LEVEL_N, SECOND_OE);
    chk("invalid", !PROTECT_EN, INVALID_ACTIVE);
    chk("pulse code", REG_PULSE_CURRENT_LEVEL[7:0], LOAD_PULSE_CODE);
    chk("hold code", REG_HOLD_CURRENT_LEVEL[5:0], LOAD_HOLD_CODE);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    repeat (40000) @(posedge CORE_CLK);
    fails++;
    end_sim;
  end
  initial begin
    void'($urandom(36));
    {SRST, CE, PROTECT_EN, IRQ_LEVEL_N, lv0, lv1} = {4'hf, 16'h0000};
    {REG_CONTROL, REG_LOAD_ENABLE, REG_LOAD_CONTROL} = 48'h0;
    REG_DATAPATH_CONTROL = 16'h2b80;
    REG_HIGH_THRESHOLDS = 32'h80888080;
    REG_PULSE_CURRENT_LEVEL = 16'($urandom);
    REG_HOLD_CURRENT_LEVEL = 16'($urandom);
    REG_PULSE_DURATION = 16'h0002;
    REG_LOAD_RISE_THRESHOLD = 16'h0040;
    flt[1] = 16'h8000;
    flt[3] = 16'h9fff;
    for (int ud = 0; ud < 2; ud++) begin
      flt[0] = {1'b1, ud[0], 14'h0003};
      flt[2] = {1'b1, ~ud[0], 14'h0002};
      REG_CONTROL = {13'h0, ud[0], 2'h0};
      rst;
      foreach (seq[i]) step(8'(seq[i]), 8'($urandom));
      $display("test debounce %0d done", ud);
    end
    // Bypassed output path, so the pass and hold choices really differ while invalid.
    flt[0] = 16'h8000;
    REG_CONTROL = 16'h0000;
    for (int m = 0; m < 4; m++) begin
      REG_DATAPATH_CONTROL[5:3] = {m[1:0], 1'($urandom_range(1))};
      step(8'hc0, 8'h10);
      ent = '{fo[0][0], fo[0][1]};
      PROTECT_EN = 1'b0;
      step(8'h10, 8'hc0);
      step(8'hc0, 8'h10);
      PROTECT_EN = 1'b1;
      step(8'h10, 8'h10);
    end
    $display("test invalid done");
    flt[0] = 16'h8003;
    flt[1] = 16'h0000;
    REG_LOAD_ENABLE = 16'h4000;
    rst;
    step(8'h20, 8'h20);
    chk("pulse", 8'h00, snap);
    step(8'h60, 8'h60);
    chk("pulse", 8'h01, snap);
    chk("hold", 8'h01, LOAD_HOLD_ON);
    REG_LOAD_ENABLE = 16'h0000;
    step(8'h60, 8'h60);
    chk("load off", 8'h00, {LOAD_HOLD_ON, LOAD_PULSE_ON});
    repeat (4) step(8'hc0, 8'hc0);
    REG_LOAD_ENABLE = 16'hc000;
    step(8'hc0, 8'hc0);
    chk("pulse", 8'h00, snap);
    REG_LOAD_CONTROL = 16'h0001;
    rst;
    step(8'h10, 8'h10);
    chk("pulse", 8'h03, snap);
    $display("test load done");
    end_sim;
  end
endmodule
